// file: bwc_pkg.sv
// Package of offsets, fields and reset values for the bridge window configuration registers.
package bwc_pkg;
	localparam logic [11:0] BWC_ADDR_W_OFS   = 12'h000;
	localparam logic [11:0] BWC_PREF_BASE_LOW   = 12'h024;
	localparam logic [11:0] BWC_PREF_LIMIT_LOW  = 12'h026;
	localparam logic [11:0] BWC_PREF_BASE_HIGH  = 12'h028;
	localparam logic [11:0] BWC_PREF_LIMIT_HIGH = 12'h02C;
	localparam logic [11:0] BWC_IO_BASE_HIGH    = 12'h030;
	localparam logic [11:0] BWC_IO_LIMIT_HIGH   = 12'h032;
	localparam logic [11:0] BWC_CAP_HEAD        = 12'h034;
	localparam logic [11:0] BWC_OPTION_ROM      = 12'h038;
	localparam logic [11:0] BWC_IRQ_LINE        = 12'h03C;
	localparam logic [11:0] BWC_IO_BASE_LOW     = 12'h01C;
	localparam logic [11:0] BWC_WORD_MASK       = 12'hFFC;
	localparam int          BWC_FIELD_LSB       = 4;
	localparam int          BWC_FIELD_MSB       = 15;
	localparam int          BWC_HALF            = 16;
	localparam logic [11:0] BWC_BASE_FIELD_RST  = 12'hFFF;
	localparam logic [11:0] BWC_LIMIT_FIELD_RST = 12'h000;
	localparam logic        BWC_PREF_CAP_RST    = 1'h1;
	localparam logic        BWC_IO_CAP_RST      = 1'h1;
	localparam logic [31:0] BWC_BASE_UP_RST     = 32'hFFFF_FFFF;
	localparam logic [31:0] BWC_LIMIT_UP_RST    = 32'h0000_0000;
	localparam logic [15:0] BWC_IO_BASE_UP_RST  = 16'hFFFF;
	localparam logic [15:0] BWC_IO_LIMIT_UP_RST = 16'h0000;
	localparam logic [7:0]  BWC_CAP_HEAD_VAL    = 8'h40;
	localparam logic [31:0] BWC_OPTION_ROM_VAL  = 32'h0000_0000;
	localparam logic [7:0]  BWC_IRQ_LINE_RST    = 8'h00;
	localparam logic [19:0] BWC_LOW_ONES        = 20'hF_FFFF;
	localparam logic [19:0] BWC_LOW_ZEROS       = 20'h0_0000;
	localparam logic [1:0]  BWC_RESP_OKAY       = 2'h0;
	localparam logic [1:0]  BWC_RESP_SLVERR     = 2'h2;
endpackage

// file: bwc_pref_window.sv
// Prefetchable window compare that decides whether an address is forwarded.
`timescale 1ns/100ps
module bwc_pref_window (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        wide_capable,
	input  wire logic [11:0] base_field,
	input  wire logic [11:0] limit_field,
	input  wire logic [31:0] base_upper,
	input  wire logic [31:0] limit_upper,
	input  wire logic [63:0] txn_addr,
	output logic             txn_hit
);
	import bwc_pkg::*;

	logic [63:0] lo_bound;
	logic [63:0] hi_bound;
	logic        hit_next;

	always_comb begin
		if (wide_capable) begin
			lo_bound = {base_upper, base_field, BWC_LOW_ZEROS};
			hi_bound = {limit_upper, limit_field, BWC_LOW_ONES};
		end else begin
			lo_bound = {32'h0000_0000, base_field, BWC_LOW_ZEROS};
			hi_bound = {32'h0000_0000, limit_field, BWC_LOW_ONES};
		end
		hit_next = (txn_addr >= lo_bound) && (txn_addr <= hi_bound);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txn_hit <= 1'b0;
		end else begin
			txn_hit <= hit_next;
		end
	end

	// The window bounds end on 1 MB edges, so comparing the upper 44 address bits is enough.
	window_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> txn_hit ==
		$past((txn_addr[63:20] >= {(wide_capable ? base_upper : 32'h0000_0000), base_field})
		&& (txn_addr[63:20] <= {(wide_capable ? limit_upper : 32'h0000_0000), limit_field})))
		else $error("window hit does not follow compare");
endmodule

// file: bwc_regs.sv
// AXI4-Lite register bank for the bridge prefetchable and I/O window registers.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module bwc_regs (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [63:0] txn_addr,
	output logic             txn_hit,
	output logic             pref_wide_addr_capable,
	output logic             io_wide_addr_capable
);
	import bwc_pkg::*;

	// ****************************************
	// Register storage
	// ****************************************
	logic [11:0] pref_base_field_reg;
	logic [11:0] pref_limit_field_reg;
	logic        pref_cap_reg;
	logic [31:0] pref_base_upper_reg;
	logic [31:0] pref_limit_upper_reg;
	logic        io_cap_reg;
	logic [15:0] io_window_base_upper_reg;
	logic [15:0] io_window_limit_upper_reg;
	logic [7:0]  irq_line_routing_reg;

	// ****************************************
	// Write channel
	// ****************************************
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;
	logic [11:0] wr_word;
	logic        wr_hit;

	function automatic logic known_word(input logic [11:0] a);
		known_word = (a == BWC_PREF_BASE_LOW) || (a == BWC_PREF_BASE_HIGH) ||
			(a == BWC_PREF_LIMIT_HIGH) || (a == BWC_IO_BASE_HIGH) ||
			(a == BWC_CAP_HEAD) || (a == BWC_OPTION_ROM) ||
			(a == BWC_IRQ_LINE) || (a == BWC_IO_BASE_LOW);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_word = aw_addr_reg & BWC_WORD_MASK;
	assign wr_hit  = known_word(wr_word);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= BWC_ADDR_W_OFS;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= BWC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? BWC_RESP_OKAY : BWC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Register updates
	// ****************************************
	logic [31:0] cur_word;
	logic [31:0] new_word;
	logic [31:0] pref_low_word;
	logic [31:0] pref_base_up_word;
	logic [31:0] pref_limit_up_word;
	logic [31:0] io_up_word;

	// The words are gathered in one process so that every register the read function
	// touches keeps them current, and the checks below see them as sampled values.
	always_comb begin
		cur_word           = read_word(wr_word);
		pref_low_word      = read_word(BWC_PREF_BASE_LOW);
		pref_base_up_word  = read_word(BWC_PREF_BASE_HIGH);
		pref_limit_up_word = read_word(BWC_PREF_LIMIT_HIGH);
		io_up_word         = read_word(BWC_IO_BASE_HIGH);
	end
	assign new_word = merge(cur_word, w_data_reg, w_strb_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pref_cap_reg         <= BWC_PREF_CAP_RST;
			pref_base_field_reg  <= BWC_BASE_FIELD_RST;
			pref_limit_field_reg <= BWC_LIMIT_FIELD_RST;
		end else if (wr_fire && wr_word == BWC_PREF_BASE_LOW) begin
			pref_cap_reg         <= new_word[0];
			pref_base_field_reg  <= new_word[BWC_FIELD_MSB:BWC_FIELD_LSB];
			pref_limit_field_reg <=
				new_word[BWC_HALF+BWC_FIELD_MSB:BWC_HALF+BWC_FIELD_LSB];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pref_base_upper_reg <= BWC_BASE_UP_RST;
		end else if (wr_fire && wr_word == BWC_PREF_BASE_HIGH && pref_cap_reg) begin
			pref_base_upper_reg <= new_word;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pref_limit_upper_reg <= BWC_LIMIT_UP_RST;
		end else if (wr_fire && wr_word == BWC_PREF_LIMIT_HIGH && pref_cap_reg) begin
			pref_limit_upper_reg <= new_word;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_cap_reg <= BWC_IO_CAP_RST;
		end else if (wr_fire && wr_word == BWC_IO_BASE_LOW) begin
			io_cap_reg <= new_word[0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_window_base_upper_reg  <= BWC_IO_BASE_UP_RST;
			io_window_limit_upper_reg <= BWC_IO_LIMIT_UP_RST;
		end else if (wr_fire && wr_word == BWC_IO_BASE_HIGH && io_cap_reg) begin
			io_window_base_upper_reg  <= new_word[BWC_HALF-1:0];
			io_window_limit_upper_reg <= new_word[2*BWC_HALF-1:BWC_HALF];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_line_routing_reg <= BWC_IRQ_LINE_RST;
		end else if (wr_fire && wr_word == BWC_IRQ_LINE) begin
			irq_line_routing_reg <= new_word[7:0];
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	function automatic logic [31:0] read_word(input logic [11:0] a);
		read_word = 32'h0000_0000;
		if (a == BWC_PREF_BASE_LOW) begin
			read_word = {pref_limit_field_reg, 3'h0, pref_cap_reg,
				pref_base_field_reg, 3'h0, pref_cap_reg};
		end else if (a == BWC_PREF_BASE_HIGH) begin
			read_word = pref_cap_reg ? pref_base_upper_reg : 32'h0000_0000;
		end else if (a == BWC_PREF_LIMIT_HIGH) begin
			read_word = pref_cap_reg ? pref_limit_upper_reg : 32'h0000_0000;
		end else if (a == BWC_IO_BASE_HIGH) begin
			if (io_cap_reg) begin
				read_word = {io_window_limit_upper_reg, io_window_base_upper_reg};
			end
		end else if (a == BWC_CAP_HEAD) begin
			read_word = {24'h00_0000, BWC_CAP_HEAD_VAL};
		end else if (a == BWC_OPTION_ROM) begin
			read_word = BWC_OPTION_ROM_VAL;
		end else if (a == BWC_IRQ_LINE) begin
			read_word = {24'h00_0000, irq_line_routing_reg};
		end else if (a == BWC_IO_BASE_LOW) begin
			read_word = {31'h0000_0000, io_cap_reg};
		end
	endfunction

	logic [11:0] rd_word;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_word = s_axi_araddr & BWC_WORD_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= BWC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_word(rd_word);
			s_axi_rresp  <= known_word(rd_word) ? BWC_RESP_OKAY : BWC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign pref_wide_addr_capable = pref_cap_reg;
	assign io_wide_addr_capable   = io_cap_reg;

	// ****************************************
	// Forwarding decision
	// ****************************************
	bwc_pref_window u_window (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.wide_capable (pref_cap_reg),
		.base_field   (pref_base_field_reg),
		.limit_field  (pref_limit_field_reg),
		.base_upper   (pref_base_upper_reg),
		.limit_upper  (pref_limit_upper_reg),
		.txn_addr     (txn_addr),
		.txn_hit      (txn_hit)
	);

	// ****************************************
	// Checks
	// ****************************************
	limit_cap_mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pref_low_word[BWC_HALF] == pref_cap_reg)
		else $error("limit capability bit does not mirror base");
	cap_reset_a: assert property (@(posedge aclk)
		$past(!aresetn) |-> pref_cap_reg == BWC_PREF_CAP_RST)
		else $error("capability bit reset value wrong");
	limit_field_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_word == BWC_PREF_BASE_LOW && w_strb_reg[3:2] == 2'h3
		|=> pref_limit_field_reg == $past(w_data_reg[31:20]))
		else $error("limit field not written");
	base_reset_a: assert property (@(posedge aclk)
		$past(!aresetn) |-> pref_base_field_reg == BWC_BASE_FIELD_RST
		&& pref_base_upper_reg == BWC_BASE_UP_RST)
		else $error("base reset value wrong");
	base_up_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_word == BWC_PREF_BASE_HIGH && pref_cap_reg && w_strb_reg == 4'hF
		|=> pref_base_upper_reg == $past(w_data_reg))
		else $error("upper base not written");
	limit_up_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_word == BWC_PREF_LIMIT_HIGH && pref_cap_reg && w_strb_reg == 4'hF
		|=> pref_limit_upper_reg == $past(w_data_reg))
		else $error("upper limit not written");
	upper_narrow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!pref_cap_reg |-> pref_base_up_word == 32'h0000_0000
		&& pref_limit_up_word == 32'h0000_0000)
		else $error("upper prefetch halves visible while narrow");
	upper_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!pref_cap_reg |=> $stable(pref_base_upper_reg) && $stable(pref_limit_upper_reg))
		else $error("upper prefetch halves changed while narrow");
	io_narrow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!io_cap_reg |-> io_up_word == 32'h0000_0000)
		else $error("upper I/O halves visible while narrow");
	cap_head_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && rd_word == BWC_CAP_HEAD
		|=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, BWC_CAP_HEAD_VAL})
		else $error("capability head wrong");
	rom_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && rd_word == BWC_OPTION_ROM
		|=> s_axi_rdata == 32'h0000_0000)
		else $error("option ROM base not zero");
	irq_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_word == BWC_IRQ_LINE && w_strb_reg[0]
		|=> irq_line_routing_reg == $past(w_data_reg[7:0]))
		else $error("interrupt line not stored");

	// A write completes in two steps: address and data both held, then the response.
	sequence write_joined_s;
		aw_held_reg && w_held_reg && !s_axi_bvalid;
	endsequence

	sequence write_answered_s;
		s_axi_bvalid && !s_axi_awready && !s_axi_wready;
	endsequence

	write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		write_joined_s |=> write_answered_s)
		else $error("write response not raised after address and data");
	read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not raised after address");
endmodule

// file: tb_bridge_window_config_regs.sv
// Self-checking testbench for the bridge window configuration register bank.
`timescale 1ns/100ps
module tb_bridge_window_config_regs;
	import bwc_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic [63:0] txn_addr = 64'h0;
	logic        txn_hit;
	logic        pref_wide_addr_capable;
	logic        io_wide_addr_capable;
	int          n_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [11:0] m_lim, m_base;
	logic        m_pc, m_ic;
	logic [31:0] m_bu, m_lu, rnd;
	logic [15:0] m_iob, m_iol;
	logic [7:0]  m_irq;
	logic [63:0] lo, hi;
	logic [11:0] tab [9] = '{BWC_IO_BASE_LOW, BWC_PREF_BASE_LOW, BWC_PREF_BASE_HIGH,
		BWC_PREF_LIMIT_HIGH, BWC_IO_BASE_HIGH, BWC_CAP_HEAD, BWC_OPTION_ROM, BWC_IRQ_LINE, 12'h040};

	bwc_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.txn_addr(txn_addr), .txn_hit(txn_hit), .pref_wide_addr_capable(pref_wide_addr_capable),
		.io_wide_addr_capable(io_wide_addr_capable));

	always #5 aclk = ~aclk;

	// ********************************************
	// Checking and reference model
	// ********************************************
	task end_sim;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask

	function automatic logic [31:0] exp_rd(input logic [11:0] a);
		case (a)
			BWC_PREF_BASE_LOW:   return {m_lim, 3'h0, m_pc, m_base, 3'h0, m_pc};
			BWC_PREF_BASE_HIGH:  return m_pc ? m_bu : 32'h0;
			BWC_PREF_LIMIT_HIGH: return m_pc ? m_lu : 32'h0;
			BWC_IO_BASE_HIGH:    return m_ic ? {m_iol, m_iob} : 32'h0;
			BWC_CAP_HEAD:        return 32'h40;
			BWC_IRQ_LINE:        return {24'h0, m_irq};
			BWC_IO_BASE_LOW:     return {31'h0, m_ic};
			default:             return 32'h0;
		endcase
	endfunction

	function automatic logic [1:0] exp_resp(input logic [11:0] a);
		return (a == 12'h040) ? BWC_RESP_SLVERR : BWC_RESP_OKAY;
	endfunction

	function automatic logic exp_hit(input logic [63:0] a);
		return (a >= {m_pc ? m_bu : 32'h0, m_base, 20'h0_0000}) &&
			(a <= {m_pc ? m_lu : 32'h0, m_lim, 20'hF_FFFF});
	endfunction

	// ********************************************
	// Bus tasks
	// ********************************************
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_h, w_h, b_h;
		logic [1:0] resp;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b_h = 1'b0;
		while (!b_h) begin
			@(negedge aclk);
			aw_h = s_axi_awvalid & s_axi_awready;
			w_h = s_axi_wvalid & s_axi_wready;
			b_h = s_axi_bvalid & s_axi_bready;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_h) s_axi_awvalid <= 1'b0;
			if (w_h) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		chk_val({30'h0, resp}, {30'h0, exp_resp(a)});
		case (a)
			BWC_PREF_BASE_LOW: begin
				m_lim = d[31:20];
				m_base = d[15:4];
				m_pc = d[0];
			end
			BWC_PREF_BASE_HIGH:  if (m_pc) m_bu = d;
			BWC_PREF_LIMIT_HIGH: if (m_pc) m_lu = d;
			BWC_IO_BASE_HIGH:    if (m_ic) {m_iol, m_iob} = d;
			BWC_IRQ_LINE:        m_irq = d[7:0];
			BWC_IO_BASE_LOW:     m_ic = d[0];
			default:             ;
		endcase
		chk_bit(pref_wide_addr_capable, m_pc);
		chk_bit(io_wide_addr_capable, m_ic);
	endtask

	task rd(input logic [11:0] a);
		logic ar_h, r_h;
		logic [31:0] data;
		logic [1:0] resp;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r_h = 1'b0;
		while (!r_h) begin
			@(negedge aclk);
			ar_h = s_axi_arvalid & s_axi_arready;
			r_h = s_axi_rvalid & s_axi_rready;
			data = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_h) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		chk_val(data, exp_rd(a));
		chk_val({30'h0, resp}, {30'h0, exp_resp(a)});
	endtask

	task model_rst;
		{m_lim, m_base, m_pc, m_ic} = {12'h000, 12'hFFF, 1'b1, 1'b1};
		{m_bu, m_lu, m_iob, m_iol, m_irq} = {32'hFFFF_FFFF, 32'h0, 16'hFFFF, 16'h0, 8'h00};
	endtask

	task win(input logic [63:0] a);
		txn_addr <= a;
		@(posedge aclk);
		@(negedge aclk);
		chk_bit(txn_hit, exp_hit(a));
		@(posedge aclk);
	endtask

	// ********************************************
	// Test sequence
	// ********************************************
	initial begin
		rnd = $urandom(32'hB8ED);
		model_rst();
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (tab[i]) rd(tab[i]);
		win(64'h0);
		foreach (tab[i]) wr(tab[i], 32'hFFFF_FFFF);
		foreach (tab[i]) rd(tab[i]);
		foreach (tab[i]) wr(tab[i], 32'h0);
		foreach (tab[i]) rd(tab[i]);
		wr(BWC_IO_BASE_LOW, 32'h1);
		wr(BWC_PREF_BASE_LOW, 32'h1);
		foreach (tab[i]) rd(tab[i]);
		repeat (150) begin
			rnd = $urandom % 9;
			if ($urandom % 2) wr(tab[rnd], $urandom);
			else rd(tab[rnd]);
			if ($urandom % 4 == 0) win({$urandom, $urandom});
		end
		// A reset in mid-run must bring every register back to its reset value.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		model_rst();
		@(posedge aclk);
		foreach (tab[i]) rd(tab[i]);
		for (int p = 1; p >= 0; p--) begin
			wr(BWC_PREF_BASE_LOW, {12'($urandom), 4'h0, 12'($urandom), 4'h1});
			rnd = $urandom;
			wr(BWC_PREF_BASE_HIGH, rnd);
			wr(BWC_PREF_LIMIT_HIGH, rnd + 32'($urandom % 2));
			wr(BWC_PREF_BASE_LOW, {m_lim, 4'h0, m_base, 3'h0, 1'(p)});
			wr(BWC_IRQ_LINE, $urandom);
			lo = {m_pc ? m_bu : 32'h0, m_base, 20'h0_0000};
			hi = {m_pc ? m_lu : 32'h0, m_lim, 20'hF_FFFF};
			win(lo);
			win(lo - 64'h1);
			win(hi);
			win(hi + 64'h1);
			win(lo + 64'(($urandom % 4) << 20));
		end
		end_sim();
	end
endmodule
